// ===== io_indexed_watchdog_timer.sv
// watchdog timer behind an index/data I/O port pair
`default_nettype none
`include "wdt_params.svh"
// Function
// - host writes register index at port 2E, data at port 2F
// - two successive writes of 87 to index port unlock access
// - writing 08 to selector 07 picks the watchdog register group
// - writing 01 to register 30 activates watchdog; inactive after reset
// - F5 bit 3 selects unit: 0 seconds (reset), 1 minutes
// - F6 zero stops timer (reset); 01..FF sets interval length
// - interval elapsing without restart asserts timeout output
// - writing count register restarts countdown from new value
// - F7 bit 7 set lets mouse activity restart timer
// - F7 bit 6 set lets keyboard activity restart timer
// - F7 bit 5 write of one forces timeout while active (register 30 = 01), self-clears
// - F7 bit 4 reads one once timer has timed out
// - writing AA to index port relocks configuration access
module io_indexed_watchdog_timer
   import wdt_pkg::*;
#(
   parameter int unsigned SEC_CYCLES = `WDT_SEC_CYCLES,
   parameter int unsigned SEC_PER_MIN = `WDT_SEC_PER_MIN
)(
   input wire logic core_clk,
   input wire logic arst_n,
   input wire logic ioWrite,
   input wire logic ioRead,
   input wire logic [15:0] ioAddr,
   input wire logic [7:0] ioWdata,
   output logic [7:0] ioRdata,
   input wire logic mouseActivity,
   input wire logic kbdActivity,
   output logic timeoutOut
);
   wdt_tick_if tb ();

   wdt_timebase #(
      .SEC_CYCLES(SEC_CYCLES),
      .SEC_PER_MIN(SEC_PER_MIN)
   ) u_timebase (
      .core_clk(core_clk),
      .arst_n(arst_n),
      .tb(tb)
   );

   lock_state_t lockState;
   lock_state_t next_lockState;
   logic [7:0] index;
   logic [7:0] next_index;
   logic [7:0] ldSel;
   logic [7:0] next_ldSel;
   logic active;
   logic next_active;
   logic [7:0] unitReg;
   logic [7:0] next_unitReg;
   logic [7:0] countReg;
   logic [7:0] next_countReg;
   logic [7:0] remain;
   logic [7:0] next_remain;
   logic mouseEn;
   logic next_mouseEn;
   logic kbdEn;
   logic next_kbdEn;
   logic expired;
   logic next_expired;
   logic [7:0] next_ioRdata;

   logic idxWr;
   logic dataWr;
   logic dataRd;
   logic wdtSel;
   logic restart;
   logic force1;

   always_comb
   begin
      idxWr = ioWrite && ioAddr == `WDT_INDEX_PORT;
      dataWr = ioWrite && ioAddr == `WDT_DATA_PORT && lockState == OPEN;
      dataRd = ioRead && ioAddr == `WDT_DATA_PORT && lockState == OPEN;
      wdtSel = ldSel == `WDT_LDN_WDT;
      force1 = dataWr && wdtSel && index == `WDT_REG_CTRL
         && ioWdata[`WDT_FORCE_BIT];
      restart = (mouseEn && mouseActivity)
         || (kbdEn && kbdActivity)
         || (dataWr && wdtSel && index == `WDT_REG_COUNT);

      next_lockState = lockState;
      if (idxWr)
      begin
         case (lockState)
            LOCKED:
               next_lockState = (ioWdata == `WDT_KEY_UNLOCK) ? KEY_ONE
                  : LOCKED;
            KEY_ONE:
               next_lockState = (ioWdata == `WDT_KEY_UNLOCK) ? OPEN
                  : LOCKED;
            OPEN:
               next_lockState = (ioWdata == `WDT_KEY_LOCK) ? LOCKED
                  : OPEN;
            default:
               next_lockState = LOCKED;
         endcase
      end

      next_index = (idxWr && lockState == OPEN) ? ioWdata : index;
      next_ldSel = ldSel;
      next_active = active;
      next_unitReg = unitReg;
      next_countReg = countReg;
      next_mouseEn = mouseEn;
      next_kbdEn = kbdEn;
      if (dataWr && index == `WDT_REG_LDSEL)
         next_ldSel = ioWdata;
      if (dataWr && wdtSel)
      begin
         case (index)
            `WDT_REG_ACT: next_active = ioWdata == `WDT_ACT_ON;
            `WDT_REG_UNIT: next_unitReg = ioWdata;
            `WDT_REG_COUNT: next_countReg = ioWdata;
            `WDT_REG_CTRL:
            begin
               next_mouseEn = ioWdata[`WDT_MOUSE_BIT];
               next_kbdEn = ioWdata[`WDT_KBD_BIT];
            end
            default: ;
         endcase
      end

      tb.minutes = unitReg[`WDT_UNIT_BIT];
      tb.restart = restart;

      next_remain = remain;
      next_expired = expired;
      if (restart)
      begin
         next_remain = (dataWr && wdtSel && index == `WDT_REG_COUNT)
            ? ioWdata : countReg;
         next_expired = 1'b0;
      end
      else if (active && remain != 8'h00 && tb.tick)
      begin
         next_remain = remain - 8'h01;
         if (remain == 8'h01)
            next_expired = 1'b1;
      end
      if (force1 && active)
         next_expired = 1'b1;

      next_ioRdata = ioRdata;
      if (dataRd)
      begin
         next_ioRdata = 8'h00;
         if (index == `WDT_REG_LDSEL)
            next_ioRdata = ldSel;
         else if (wdtSel)
         begin
            case (index)
               `WDT_REG_ACT: next_ioRdata = {7'h00, active};
               `WDT_REG_UNIT: next_ioRdata = unitReg;
               `WDT_REG_COUNT: next_ioRdata = remain;
               `WDT_REG_CTRL: next_ioRdata = {mouseEn, kbdEn, 1'b0,
                  expired, 4'h0};
               default: next_ioRdata = 8'h00;
            endcase
         end
      end
   end

   always_ff @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         lockState <= LOCKED;
         index <= `WDT_RST_BYTE;
         ldSel <= `WDT_RST_BYTE;
         active <= 1'b0;
         unitReg <= `WDT_RST_BYTE;
         countReg <= `WDT_RST_BYTE;
         remain <= `WDT_RST_BYTE;
         mouseEn <= 1'b0;
         kbdEn <= 1'b0;
         expired <= 1'b0;
         ioRdata <= `WDT_RST_BYTE;
      end
      else
      begin
         lockState <= next_lockState;
         index <= next_index;
         ldSel <= next_ldSel;
         active <= next_active;
         unitReg <= next_unitReg;
         countReg <= next_countReg;
         remain <= next_remain;
         mouseEn <= next_mouseEn;
         kbdEn <= next_kbdEn;
         expired <= next_expired;
         ioRdata <= next_ioRdata;
      end
   end

   assign timeoutOut = expired;

   sequence s_key_first;
      lockState == LOCKED && idxWr && ioWdata == `WDT_KEY_UNLOCK;
   endsequence

   sequence s_key_second;
      idxWr && ioWdata == `WDT_KEY_UNLOCK;
   endsequence

   property p_key_one;
      @(posedge core_clk) disable iff (!arst_n)
      s_key_first |=> lockState == KEY_ONE;
   endproperty
   a_key_one: assert property (p_key_one) else $error("key lost");

   // idle cycle between the keys keeps the half-open state
   property p_unlock;
      @(posedge core_clk) disable iff (!arst_n)
      s_key_first ##1 !idxWr ##1 s_key_second |=> lockState == OPEN;
   endproperty
   a_unlock: assert property (p_unlock) else $error("unlock failed");

   property p_relock;
      @(posedge core_clk) disable iff (!arst_n)
      (lockState == OPEN && idxWr && ioWdata == `WDT_KEY_LOCK)
      |=> lockState == LOCKED;
   endproperty
   a_relock: assert property (p_relock) else $error("relock failed");

   property p_locked_ignore;
      @(posedge core_clk) disable iff (!arst_n)
      (lockState != OPEN && ioWrite && ioAddr == `WDT_DATA_PORT)
      |=> $stable(countReg) && $stable(active) && $stable(ldSel);
   endproperty
   a_locked_ignore: assert property (p_locked_ignore)
      else $error("locked write took effect");

   property p_reload;
      @(posedge core_clk) disable iff (!arst_n)
      (dataWr && wdtSel && index == `WDT_REG_COUNT)
      |=> remain == $past(ioWdata) && !timeoutOut;
   endproperty
   a_reload: assert property (p_reload) else $error("count not reloaded");

   property p_force;
      @(posedge core_clk) disable iff (!arst_n)
      (force1 && active) |=> timeoutOut;
   endproperty
   a_force: assert property (p_force) else $error("force missed");

   property p_expire;
      @(posedge core_clk) disable iff (!arst_n)
      (active && remain == 8'h01 && tb.tick && !restart) |=> timeoutOut;
   endproperty
   a_expire: assert property (p_expire) else $error("no timeout");

   property p_inactive;
      @(posedge core_clk) disable iff (!arst_n)
      (!active && !restart) |=> $stable(remain);
   endproperty
   a_inactive: assert property (p_inactive) else $error("counts inactive");

   property p_mouse;
      @(posedge core_clk) disable iff (!arst_n)
      (mouseEn && mouseActivity && !force1
         && !(dataWr && wdtSel && index == `WDT_REG_COUNT))
      |=> remain == $past(countReg) && !timeoutOut;
   endproperty
   a_mouse: assert property (p_mouse) else $error("mouse restart lost");

   property p_status;
      @(posedge core_clk) disable iff (!arst_n)
      (dataRd && wdtSel && index == `WDT_REG_CTRL)
      |=> ioRdata[`WDT_STATUS_BIT] == $past(expired);
   endproperty
   a_status: assert property (p_status) else $error("status wrong");
endmodule // io_indexed_watchdog_timer
`default_nettype wire

// ===== wdt_params.svh
// constants for the indexed watchdog timer
`ifndef WDT_PARAMS_SVH
`define WDT_PARAMS_SVH
`define WDT_INDEX_PORT 16'h002E
`define WDT_DATA_PORT 16'h002F
`define WDT_KEY_UNLOCK 8'h87
`define WDT_KEY_LOCK 8'hAA
`define WDT_REG_LDSEL 8'h07
`define WDT_REG_ACT 8'h30
`define WDT_REG_UNIT 8'hF5
`define WDT_REG_COUNT 8'hF6
`define WDT_REG_CTRL 8'hF7
`define WDT_LDN_WDT 8'h08
`define WDT_ACT_ON 8'h01
`define WDT_UNIT_BIT 3
`define WDT_MOUSE_BIT 7
`define WDT_KBD_BIT 6
`define WDT_FORCE_BIT 5
`define WDT_STATUS_BIT 4
`define WDT_RST_BYTE 8'h00
`define WDT_CLK_HZ 250000000
`define WDT_SECOND_S 1
`define WDT_SEC_CYCLES (`WDT_CLK_HZ * `WDT_SECOND_S)
`define WDT_SEC_PER_MIN 60
`endif

// ===== wdt_pkg.sv
// types for the indexed watchdog timer
`default_nettype none
package wdt_pkg;
   typedef enum logic [1:0] {
      LOCKED = 2'b00,
      KEY_ONE = 2'b01,
      OPEN = 2'b10
   } lock_state_t;
endpackage
`default_nettype wire

// ===== wdt_tick_if.sv
// timebase tick channel between watchdog core and prescaler
`default_nettype none
interface wdt_tick_if;
   logic minutes;
   logic restart;
   logic tick;
   modport ctrl (output minutes, output restart, input tick);
   modport gen (input minutes, input restart, output tick);
endinterface
`default_nettype wire

// ===== wdt_timebase.sv
// one-second / one-minute tick generator
`default_nettype none
`include "wdt_params.svh"
module wdt_timebase
   import wdt_pkg::*;
#(
   parameter int unsigned SEC_CYCLES = `WDT_SEC_CYCLES,
   parameter int unsigned SEC_PER_MIN = `WDT_SEC_PER_MIN
)(
   input wire logic core_clk,
   input wire logic arst_n,
   wdt_tick_if.gen tb
);
   // refuse prescaler settings the 32-bit and 8-bit counters cannot serve
   if (SEC_CYCLES < 2 || SEC_PER_MIN < 1 || SEC_PER_MIN > 255)
   begin : g_bad_params
      $error("wdt_timebase: bad parameters");
   end

   logic [31:0] cyc;
   logic [31:0] next_cyc;
   logic [7:0] secs;
   logic [7:0] next_secs;
   logic secTick;
   logic next_tick;

   always_comb
   begin
      next_cyc = cyc + 32'h00000001;
      next_secs = secs;
      next_tick = 1'b0;
      secTick = (cyc == SEC_CYCLES - 1);
      if (tb.restart)
      begin
         next_cyc = 32'h00000000;
         next_secs = 8'h00;
      end
      else if (secTick)
      begin
         next_cyc = 32'h00000000;
         if (!tb.minutes)
            next_tick = 1'b1;
         else if (secs == 8'(SEC_PER_MIN - 1))
         begin
            next_secs = 8'h00;
            next_tick = 1'b1;
         end
         else
            next_secs = secs + 8'h01;
      end
   end

   always_ff @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         cyc <= 32'h00000000;
         secs <= 8'h00;
         tb.tick <= 1'b0;
      end
      else
      begin
         cyc <= next_cyc;
         secs <= next_secs;
         tb.tick <= next_tick;
      end
   end
endmodule // wdt_timebase
`default_nettype wire

// ===== host_io_model.sv
// host side model issuing index/data port cycles
`default_nettype none
`include "wdt_params.svh"
module host_io_model
(
   input wire logic core_clk,
   output var logic ioWrite,
   output var logic ioRead,
   output var logic [15:0] ioAddr,
   output var logic [7:0] ioWdata,
   input wire logic [7:0] ioRdata
);
   timeunit 1ns;
   timeprecision 1ps;
   initial
   begin
      ioWrite = 1'b0;
      ioRead = 1'b0;
      ioAddr = 16'h0000;
      ioWdata = 8'h00;
   end
   // released lines show inverted leftovers
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge core_clk);
      ioWrite <= 1'b1;
      ioAddr <= a;
      ioWdata <= d;
      @(posedge core_clk);
      ioWrite <= 1'b0;
      ioAddr <= ~a;
      ioWdata <= ~d;
   endtask
   task automatic rd(input logic [15:0] a, output logic [7:0] d);
      @(posedge core_clk);
      ioRead <= 1'b1;
      ioAddr <= a;
      @(posedge core_clk);
      ioRead <= 1'b0;
      ioAddr <= ~a;
      @(posedge core_clk);
      d = ioRdata;
   endtask
   task automatic unlock;
      wr(`WDT_INDEX_PORT, `WDT_KEY_UNLOCK);
      wr(`WDT_INDEX_PORT, `WDT_KEY_UNLOCK);
      wr(`WDT_INDEX_PORT, `WDT_REG_LDSEL);
      wr(`WDT_DATA_PORT, `WDT_LDN_WDT);
   endtask
   task automatic lock;
      wr(`WDT_INDEX_PORT, `WDT_KEY_LOCK);
   endtask
   task automatic reg_wr(input logic [7:0] r, input logic [7:0] d);
      wr(`WDT_INDEX_PORT, {8'h00, r});
      wr(`WDT_DATA_PORT, d);
   endtask
   task automatic reg_rd(input logic [7:0] r, output logic [7:0] d);
      wr(`WDT_INDEX_PORT, {8'h00, r});
      rd(`WDT_DATA_PORT, d);
   endtask
endmodule // host_io_model
`default_nettype wire

// ===== io_indexed_watchdog_timer_test.sv
// self-checking bench for the indexed watchdog
`default_nettype none
`include "wdt_params.svh"
module io_indexed_watchdog_timer_test;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int SC = 10;
   localparam int SPM = 3;
   logic core_clk = 1'b0;
   logic arst_n = 1'b0;
   logic mouseActivity = 1'b0;
   logic kbdActivity = 1'b0;
   logic ioWrite;
   logic ioRead;
   logic [15:0] ioAddr;
   logic [7:0] ioWdata;
   logic [7:0] ioRdata;
   logic timeoutOut;
   int failures = 0;
   int n_compared = 0;
   integer seed = 32'hCE17;
   // model state of the restart enables and status
   int mEn = 0;
   int kEn = 0;
   int expd = 0;
   always #2 core_clk = ~core_clk;
   host_io_model i_host_io_model (.core_clk(core_clk), .ioWrite(ioWrite),
      .ioRead(ioRead), .ioAddr(ioAddr), .ioWdata(ioWdata),
      .ioRdata(ioRdata));
   io_indexed_watchdog_timer #(.SEC_CYCLES(SC), .SEC_PER_MIN(SPM))
   i_io_indexed_watchdog_timer (.core_clk(core_clk), .arst_n(arst_n),
      .ioWrite(ioWrite), .ioRead(ioRead), .ioAddr(ioAddr),
      .ioWdata(ioWdata), .ioRdata(ioRdata), .mouseActivity(mouseActivity),
      .kbdActivity(kbdActivity), .timeoutOut(timeoutOut));
   function automatic logic [7:0] f7exp;
      return {mEn[0], kEn[0], 1'b0, expd[0], 4'h0};
   endfunction
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         failures++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic tchk(input logic e);
      @(negedge core_clk);
      chk({7'h00, timeoutOut}, {7'h00, e});
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge core_clk);
   endtask
   task automatic pulse(input logic m);
      @(posedge core_clk);
      mouseActivity <= m;
      kbdActivity <= ~m;
      @(posedge core_clk);
      mouseActivity <= 1'b0;
      kbdActivity <= 1'b0;
   endtask
   task automatic close_out;
      $display("compared %0d mismatches %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   initial
   begin
      #40000;
      failures++;
      close_out();
   end
   initial
   begin
      logic [7:0] v;
      int n;
      int u;
      repeat (4) @(posedge core_clk);
      arst_n <= 1'b1;
      // broken key sequence leaves the port locked
      i_host_io_model.wr(`WDT_INDEX_PORT, `WDT_KEY_UNLOCK);
      i_host_io_model.wr(`WDT_INDEX_PORT, 8'hF6);
      i_host_io_model.wr(`WDT_INDEX_PORT, `WDT_KEY_UNLOCK);
      i_host_io_model.reg_wr(`WDT_REG_LDSEL, `WDT_LDN_WDT);
      i_host_io_model.reg_wr(`WDT_REG_ACT, `WDT_ACT_ON);
      i_host_io_model.reg_wr(`WDT_REG_CTRL, 8'h20);
      cyc(20);
      tchk(1'b0);
      i_host_io_model.unlock();
      i_host_io_model.reg_wr(`WDT_REG_CTRL, 8'h20);
      cyc(5);
      tchk(1'b0);
      i_host_io_model.reg_rd(`WDT_REG_COUNT, v);
      chk(v, 8'h00);
      i_host_io_model.reg_rd(`WDT_REG_CTRL, v);
      chk(v, f7exp());
      i_host_io_model.reg_rd(`WDT_REG_UNIT, v);
      chk(v, 8'h00);
      $display("test lock and reset done");
      i_host_io_model.reg_wr(`WDT_REG_ACT, `WDT_ACT_ON);
      i_host_io_model.reg_rd(`WDT_REG_ACT, v);
      chk(v, 8'h01);
      for (u = 1; u >= 0; u--)
      begin
         i_host_io_model.reg_wr(`WDT_REG_UNIT, u[0] ? 8'h08 : 8'h00);
         n = 1 + ($random(seed) & 3);
         i_host_io_model.reg_wr(`WDT_REG_COUNT, n[7:0]);
         expd = 0;
         cyc(2);
         tchk(1'b0);
         cyc(n * SC * (u ? SPM : 1) - 6);
         tchk(1'b0);
         cyc(8);
         tchk(1'b1);
         expd = 1;
         i_host_io_model.reg_rd(`WDT_REG_CTRL, v);
         chk(v, f7exp());
         i_host_io_model.reg_rd(`WDT_REG_COUNT, v);
         chk(v, 8'h00);
      end
      $display("test countdown done");
      i_host_io_model.reg_wr(`WDT_REG_COUNT, 8'h03);
      cyc(18);
      i_host_io_model.reg_wr(`WDT_REG_COUNT, 8'h03);
      cyc(24);
      tchk(1'b0);
      mEn = 1;
      kEn = 1;
      i_host_io_model.reg_wr(`WDT_REG_CTRL, 8'hC0);
      // random gaps stay well inside the three-second interval
      for (n = 0; n < 4; n++)
      begin
         cyc(10 + ($random(seed) & 7));
         pulse(n[0]);
      end
      tchk(1'b0);
      mEn = 0;
      i_host_io_model.reg_wr(`WDT_REG_CTRL, 8'h40);
      i_host_io_model.reg_wr(`WDT_REG_COUNT, 8'h03);
      repeat (3)
      begin
         cyc(10);
         pulse(1'b1);
      end
      cyc(4);
      tchk(1'b1);
      pulse(1'b0);
      cyc(2);
      tchk(1'b0);
      $display("test activity restart done");
      i_host_io_model.reg_wr(`WDT_REG_COUNT, 8'h00);
      cyc(40);
      tchk(1'b0);
      // another register group hides the watchdog registers
      i_host_io_model.reg_wr(`WDT_REG_LDSEL, 8'h05);
      i_host_io_model.reg_wr(`WDT_REG_COUNT, 8'h05);
      i_host_io_model.reg_rd(`WDT_REG_CTRL, v);
      chk(v, 8'h00);
      i_host_io_model.reg_rd(`WDT_REG_LDSEL, v);
      chk(v, 8'h05);
      i_host_io_model.reg_wr(`WDT_REG_LDSEL, `WDT_LDN_WDT);
      i_host_io_model.reg_rd(`WDT_REG_COUNT, v);
      chk(v, 8'h00);
      i_host_io_model.reg_wr(`WDT_REG_CTRL, 8'h60);
      cyc(3);
      tchk(1'b1);
      expd = 1;
      i_host_io_model.reg_rd(`WDT_REG_CTRL, v);
      chk(v, f7exp());
      i_host_io_model.lock();
      i_host_io_model.reg_wr(`WDT_REG_COUNT, 8'h05);
      cyc(4);
      tchk(1'b1);
      i_host_io_model.rd(`WDT_DATA_PORT, v);
      chk(v, f7exp());
      $display("test force and relock done");
      arst_n <= 1'b0;
      cyc(2);
      arst_n <= 1'b1;
      mEn = 0;
      kEn = 0;
      expd = 0;
      tchk(1'b0);
      i_host_io_model.unlock();
      i_host_io_model.reg_rd(`WDT_REG_CTRL, v);
      chk(v, f7exp());
      i_host_io_model.reg_rd(`WDT_REG_ACT, v);
      chk(v, 8'h00);
      i_host_io_model.reg_rd(`WDT_REG_COUNT, v);
      chk(v, 8'h00);
      $display("test mid-run reset done");
      close_out();
   end
endmodule // io_indexed_watchdog_timer_test
`default_nettype wire
